// file: verilog/chp_top.sv
/*
  capacity hold positioner and remote start qualification.
  assumes a 10 MHz core_clk; analog codes and the start contact arrive
  from outside the clock domain, panel status comes from core_clk logic.
*/
// Overview of operation
// - an error under 0.4 percent of full scale leaves the actuator off.
// - an error from deadband to 10 percent energizes for a proportional time.
// - an error above 10 percent drives continuously until it drops back.
// - with a slide the hold is a slide position; without, speed equals it.
// - combined mode maps 4-12 mA to slide 0-100 and 12-20 mA to speed min-max.
// - in combined mode speed rises only once the slide is at full travel.
// - capacity changes at fixed rates, slide and speed rates being different.
// - ready-to-start needs stopped, remote, no inhibit, no recycle, no trip.
// - while ready, closing the remote start contact starts the compressor.
// - the remote start contact is honoured only in remote mode.
// - under direct control network writes to the control block are refused.
// - outside combined mode 4 mA means 0 and 20 mA means 100 percent.
`timescale 1ns/10ps
`default_nettype none
`include "chp_regs.svh"
module chp_top
#(
  parameter int SLICE_CYC = `CHP_SLICE_CYC,
  parameter int RAMP_CYC  = `CHP_RAMP_CYC
)
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // configuration and panel status
  input  wire logic [1:0]  mode,
  input  wire logic        remote_mode,
  input  wire logic        direct_io,
  input  wire logic        running,
  input  wire logic        start_inhibit,
  input  wire logic        anti_recycle,
  input  wire logic        trip,
  // pins from outside the clock domain
  input  wire logic [11:0] hold_code,
  input  wire logic [9:0]  slide_pos_in,
  input  wire logic        remote_start_in,
  // network write qualification
  input  wire logic        net_wr_en,
  input  wire logic [15:0] net_wr_addr,
  output var  logic        net_wr_ok,
  output var  logic        net_wr_reject,
  // actuators and remote handshake
  output var  logic        slide_inc,
  output var  logic        slide_dec,
  output var  logic [9:0]  speed_cmd,
  output var  logic        ready_to_start,
  output var  logic        start_req,
  output var  logic        stop_req
);
  localparam int SLW = $clog2(SLICE_CYC + 1);
  localparam int RPW = $clog2(RAMP_CYC + 1);

  chp_chan_if slide_ch ();
  chp_chan_if speed_ch ();

  logic [11:0] hold_meta;
  logic [11:0] hold_s;
  logic [9:0]  slide_meta;
  logic [9:0]  slide_s;
  logic        start_meta;
  logic        start_s;
  logic        start_prev;
  logic [SLW-1:0] slice_cnt;
  logic [6:0]     slice_idx;
  logic [RPW-1:0] ramp_cnt;
  logic           slice_en;
  logic           tick_en;
  logic           ramp_en;

  // two-stage synchronisers for every pin input
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      hold_meta  <= '0;
      hold_s     <= '0;
      slide_meta <= '0;
      slide_s    <= '0;
      start_meta <= 1'b0;
      start_s    <= 1'b0;
      start_prev <= 1'b0;
    end
    else
    begin
      hold_meta  <= hold_code;
      hold_s     <= hold_meta;
      slide_meta <= slide_pos_in;
      slide_s    <= slide_meta;
      start_meta <= remote_start_in;
      start_s    <= start_meta;
      start_prev <= start_s;
    end
  end

  // dividers: slice enable, control tick every slices-per-tick, speed ramp
  assign slice_en = (slice_cnt == SLW'(SLICE_CYC - 1));
  assign tick_en  = slice_en && (slice_idx == 7'(`CHP_SLICES - 1));
  assign ramp_en  = (ramp_cnt == RPW'(RAMP_CYC - 1));

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      slice_cnt <= '0;
      slice_idx <= '0;
      ramp_cnt  <= '0;
    end
    else
    begin
      slice_cnt <= slice_en ? '0 : slice_cnt + SLW'(1);
      if (slice_en)
        slice_idx <= tick_en ? '0 : slice_idx + 7'd1;
      ramp_cnt  <= ramp_en ? '0 : ramp_cnt + RPW'(1);
    end
  end

  // hold scaling: code * 1001 / 4096 maps 4..20 mA onto 0..1000
  logic [21:0] hold_prod;
  logic [9:0]  hold_pct;
  logic        hold_upper;
  logic [9:0]  comb_slide_tgt;
  logic [9:0]  comb_speed_tgt;
  logic        is_no_slide;
  logic        is_combined;
  logic        slide_full;
  logic [9:0]  speed_tgt_raw;

  assign hold_prod  = 22'(hold_s) * `CHP_HOLD_GAIN;
  assign hold_pct   = hold_prod[21:12];
  assign hold_upper = (hold_s >= `CHP_HOLD_MID);
  // lower half doubles onto slide travel, upper half onto speed
  assign comb_slide_tgt = hold_upper ? `CHP_POS_FS
                        : 10'(hold_pct << 1);
  assign comb_speed_tgt = hold_upper ? 10'((hold_pct - `CHP_POS_HALF) << 1)
                        : 10'h000;
  assign is_no_slide = (mode == 2'(chp_pkg::CHP_NO_SLIDE));
  assign is_combined = (mode == 2'(chp_pkg::CHP_COMBINED));
  assign slide_full  = (slide_s >= `CHP_POS_FS - `CHP_DEADBAND);
  assign speed_tgt_raw = is_combined ? comb_speed_tgt : hold_pct;

  // channel hookup; in combined mode speed may only be lowered until the slide is full
  assign slide_ch.target   = is_combined ? comb_slide_tgt : hold_pct;
  assign slide_ch.position = slide_s;
  assign slide_ch.enable   = !is_no_slide;
  assign slide_ch.tick     = tick_en;
  assign slide_ch.slice    = slice_en;
  assign speed_ch.target   = (is_combined && !slide_full
                              && speed_tgt_raw > speed_cmd)
                           ? speed_cmd : speed_tgt_raw;
  assign speed_ch.position = speed_cmd;
  assign speed_ch.enable   = is_no_slide || is_combined;
  assign speed_ch.tick     = tick_en;
  assign speed_ch.slice    = slice_en;

  chp_positioner u_slide
  (
    .core_clk (core_clk),
    .rst      (rst),
    .ch       (slide_ch)
  );

  chp_positioner u_speed
  (
    .core_clk (core_clk),
    .rst      (rst),
    .ch       (speed_ch)
  );

  // speed command steps one count per ramp enable while energized; the
  // slide moves at its actuator's own rate, so the two profiles differ
  logic speed_up_ok;
  logic speed_dn_ok;
  assign speed_up_ok = speed_ch.drive_up && speed_cmd < `CHP_POS_FS
                       && (!is_combined || slide_full);
  assign speed_dn_ok = speed_ch.drive_down && speed_cmd != 10'h000;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      speed_cmd <= '0;
      slide_inc <= 1'b0;
      slide_dec <= 1'b0;
    end
    else
    begin
      if (ramp_en && speed_up_ok)
        speed_cmd <= speed_cmd + 10'd1;
      else if (ramp_en && speed_dn_ok)
        speed_cmd <= speed_cmd - 10'd1;
      slide_inc <= slide_ch.drive_up && !is_no_slide;
      slide_dec <= slide_ch.drive_down && !is_no_slide;
    end
  end

  // start qualification; the contact is dead outside remote mode
  logic ready_cond;
  logic start_close;
  logic start_open;
  logic in_ctl_blk;
  assign ready_cond  = !running && remote_mode && !start_inhibit
                       && !anti_recycle && !trip;
  assign start_close = start_s && !start_prev && remote_mode;
  assign start_open  = !start_s && start_prev && remote_mode;
  assign in_ctl_blk  = (net_wr_addr >= `CHP_CTL_BLK_LO)
                       && (net_wr_addr <= `CHP_CTL_BLK_HI);

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ready_to_start <= 1'b0;
      start_req      <= 1'b0;
      stop_req       <= 1'b0;
      net_wr_ok      <= 1'b0;
      net_wr_reject  <= 1'b0;
    end
    else
    begin
      ready_to_start <= ready_cond;
      start_req      <= start_close && ready_to_start;
      stop_req       <= start_open && running;
      net_wr_ok      <= net_wr_en && !(direct_io && in_ctl_blk);
      net_wr_reject  <= net_wr_en && direct_io && in_ctl_blk;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  ready_blocked_a: assert property (
    (running || trip || anti_recycle || start_inhibit || !remote_mode)
      |=> !ready_to_start)
    else $error("ready-to-start shown while a start is blocked");
  start_on_close_a: assert property (
    ready_to_start && remote_mode && start_s && !start_prev |=> start_req)
    else $error("closed start contact did not start compressor");
  local_ignore_a: assert property (
    !remote_mode |=> !start_req)
    else $error("start honoured outside remote mode");
  blk_reject_a: assert property (
    net_wr_en && direct_io && in_ctl_blk |=> net_wr_reject && !net_wr_ok)
    else $error("control block write accepted under direct control");
  speed_wait_a: assert property (
    is_combined && !slide_full |=> speed_cmd <= $past(speed_cmd))
    else $error("speed raised before slide reached full travel");
  ramp_rate_a: assert property (
    !ramp_en |=> $stable(speed_cmd))
    else $error("speed command changed off the ramp rate");
  no_slide_off_a: assert property (
    is_no_slide |=> !slide_inc && !slide_dec)
    else $error("slide driven in no-slide mode");
  cover_start_c: cover property (start_req);
  cover_reject_c: cover property (net_wr_reject);
  cover_ramp_c: cover property (is_combined && ramp_en && speed_up_ok);
endmodule
`default_nettype wire

// file: verilog/chp_regs.svh
/*
  constants of the capacity hold positioner: scales, bands, timing.
  assumes a 10 MHz core clock; included by bare name.
*/
`ifndef CHP_REGS_SVH
`define CHP_REGS_SVH
// positions and targets are in tenths of a percent of full scale
`define CHP_POS_FS        10'h03e8
`define CHP_POS_HALF      10'h01f4
`define CHP_DEADBAND      10'h0004
`define CHP_PROP_BAND     10'h0064
// hold input: 12-bit code, 0 = 4 mA, 4095 = 20 mA, mid code = 12 mA
`define CHP_HOLD_MID      12'h0800
`define CHP_HOLD_GAIN     22'h00_03e9
// control block register range that direct control locks
`define CHP_CTL_BLK_LO    16'h9e34
`define CHP_CTL_BLK_HI    16'h9e41
// timing: figures in their own units, cycles derived from the clock
`define CHP_CLK_PERIOD_NS 100
`define CHP_TICK_US       1000000
`define CHP_SLICES        100
`define CHP_RAMP_STEP_US  20000
`define CHP_SLICE_CYC     \
  (`CHP_TICK_US * 1000 / `CHP_CLK_PERIOD_NS / `CHP_SLICES)
`define CHP_RAMP_CYC      (`CHP_RAMP_STEP_US * 1000 / `CHP_CLK_PERIOD_NS)
`endif

// file: verilog/chp_pkg.sv
/*
  types of the capacity hold positioner.
  assumes chp_regs.svh for all numeric constants.
*/
`default_nettype none
package chp_pkg;
  // actuator arrangement selected on the panel
  typedef enum logic [1:0] {
    CHP_SLIDE_ONLY,
    CHP_NO_SLIDE,
    CHP_COMBINED
  } chp_mode_t;
  // band in which the latest error fell
  typedef enum logic [1:0] {
    CHP_BAND_DEAD,
    CHP_BAND_PROP,
    CHP_BAND_FULL
  } chp_band_t;
endpackage
`default_nettype wire

// file: verilog/chp_chan_if.sv
/*
  one actuator channel between the control top and a positioner.
  assumes both ends run on core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
interface chp_chan_if;
  logic [9:0] target;
  logic [9:0] position;
  logic       enable;
  logic       tick;
  logic       slice;
  logic       drive_up;
  logic       drive_down;
  modport ctl (output target, position, enable, tick, slice,
               input drive_up, drive_down);
  modport pos (input target, position, enable, tick, slice,
               output drive_up, drive_down);
endinterface
`default_nettype wire

// file: verilog/chp_positioner.sv
/*
  deadband / proportional / continuous positioner for one actuator.
  assumes tick and slice are one-cycle enables, slices per tick fixed.
*/
`timescale 1ns/10ps
`default_nettype none
`include "chp_regs.svh"
module chp_positioner
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // channel
  chp_chan_if.pos  ch
);
  logic signed [10:0] err;
  logic        [9:0]  mag;
  logic               err_up;
  chp_pkg::chp_band_t band;
  logic        [9:0]  on_left;
  logic        [9:0]  next_on_left;
  logic               dir_up;
  logic               next_dir_up;

  // error and its band, re-evaluated at every tick
  assign err    = $signed({1'b0, ch.target}) - $signed({1'b0, ch.position});
  assign err_up = !err[10];
  assign mag    = err[10] ? 10'(-err) : err[9:0];
  assign band   = (mag < `CHP_DEADBAND)  ? chp_pkg::CHP_BAND_DEAD :
                  (mag < `CHP_PROP_BAND) ? chp_pkg::CHP_BAND_PROP :
                                           chp_pkg::CHP_BAND_FULL;

  // on-time in slices: none in the deadband, error size in the proportional band,
  // whole tick above it so that a large error keeps the actuator energized
  always_comb
  begin
    next_on_left = on_left;
    next_dir_up  = dir_up;
    if (!ch.enable)
      next_on_left = '0;
    else if (ch.tick)
    begin
      next_dir_up = err_up;
      case (band)
        chp_pkg::CHP_BAND_DEAD: next_on_left = '0;
        chp_pkg::CHP_BAND_PROP: next_on_left = mag;
        chp_pkg::CHP_BAND_FULL: next_on_left = 10'(`CHP_SLICES);
        default:                next_on_left = '0;
      endcase
    end
    else if (ch.slice && on_left != '0)
      next_on_left = on_left - 10'd1;
  end

  // registered drive outputs follow the remaining on-time
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      on_left       <= '0;
      dir_up        <= 1'b0;
      ch.drive_up   <= 1'b0;
      ch.drive_down <= 1'b0;
    end
    else
    begin
      on_left       <= next_on_left;
      dir_up        <= next_dir_up;
      ch.drive_up   <= (next_on_left != '0) && next_dir_up;
      ch.drive_down <= (next_on_left != '0) && !next_dir_up;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  deadband_idle_a: assert property (
    ch.tick && ch.enable && mag < `CHP_DEADBAND
      |=> !ch.drive_up && !ch.drive_down)
    else $error("actuator energized inside the deadband");
  prop_band_on_a: assert property (
    ch.tick && ch.enable && mag >= `CHP_DEADBAND && mag < `CHP_PROP_BAND
      |=> (ch.drive_up || ch.drive_down) && on_left == $past(mag))
    else $error("proportional on-time does not match error");
  full_drive_a: assert property (
    ch.tick && ch.enable && mag >= `CHP_PROP_BAND
      |=> (ch.drive_up || ch.drive_down) [*8])
    else $error("large error not driven continuously");
  drive_sign_a: assert property (
    ch.tick && ch.enable && err_up && mag >= `CHP_DEADBAND
      |=> ch.drive_up && !ch.drive_down)
    else $error("drive direction disagrees with error sign");
  cover_full_c: cover property (ch.tick && band == chp_pkg::CHP_BAND_FULL);
  cover_prop_c: cover property (ch.tick && band == chp_pkg::CHP_BAND_PROP);
endmodule
`default_nettype wire

// file: sim/chp_remote_model.sv
/*
  remote supervisory controller: closes the remote start contact.
  assumes core_clk timing; want_start and obey come from the bench.
*/
`timescale 1ns/10ps
`default_nettype none
module chp_remote_model
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // commands from the bench
  input  wire logic want_start,
  input  wire logic obey,
  // handshake with the panel
  input  wire logic ready_to_start,
  output var  logic remote_start_in
);
  // once closed the contact holds, since ready means nothing while running;
  // obey low lets a scenario close it without waiting for ready
  always_ff @(posedge core_clk)
  begin
    if (rst || !want_start)
      remote_start_in <= 1'b0;
    else if (remote_start_in)
      remote_start_in <= 1'b1;
    else if (ready_to_start || !obey)
      remote_start_in <= 1'b1;
  end
endmodule
`default_nettype wire

// file: sim/chp_top_bench.sv
/*
  self-checking bench of the capacity hold positioner top.
  assumes shortened slice and ramp counts; inputs change on falling edges.
*/
`timescale 1ns/10ps
`default_nettype none
`define check_eq(got, exp, msg) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("unexpected at %0t: %s", $time, msg); \
    end \
  end
module chp_top_bench;
  // slice 2 and ramp 4 keep the design's ratio so speed cannot overshoot
  localparam int SLICE = 2;
  localparam int RAMP  = 4;
  localparam int TICK  = SLICE * 100;
  logic        core_clk;
  logic        rst;
  logic [1:0]  mode;
  logic        remote_mode;
  logic        direct_io;
  logic        running;
  logic        start_inhibit;
  logic        anti_recycle;
  logic        trip;
  logic [11:0] hold_code;
  logic [9:0]  slide_pos_in;
  logic        remote_start_in;
  logic        net_wr_en;
  logic [15:0] net_wr_addr;
  logic        net_wr_ok;
  logic        net_wr_reject;
  logic        slide_inc;
  logic        slide_dec;
  logic [9:0]  speed_cmd;
  logic        ready_to_start;
  logic        start_req;
  logic        stop_req;
  logic        want_start;
  logic        obey;
  int          failures;
  int          n_compared;
  int          up_cnt;
  int          dn_cnt;
  int          errs [8] = '{3, 4, 99, 100, -3, -4, -50, -250};
  logic [9:0]  s0;

  chp_top #(.SLICE_CYC(SLICE), .RAMP_CYC(RAMP)) chp_top_inst
  (
    .core_clk(core_clk), .rst(rst), .mode(mode),
    .remote_mode(remote_mode), .direct_io(direct_io), .running(running),
    .start_inhibit(start_inhibit), .anti_recycle(anti_recycle),
    .trip(trip), .hold_code(hold_code), .slide_pos_in(slide_pos_in),
    .remote_start_in(remote_start_in), .net_wr_en(net_wr_en),
    .net_wr_addr(net_wr_addr), .net_wr_ok(net_wr_ok),
    .net_wr_reject(net_wr_reject), .slide_inc(slide_inc),
    .slide_dec(slide_dec), .speed_cmd(speed_cmd),
    .ready_to_start(ready_to_start), .start_req(start_req),
    .stop_req(stop_req)
  );
  chp_remote_model chp_remote_model_inst
  (
    .core_clk(core_clk), .rst(rst), .want_start(want_start), .obey(obey),
    .ready_to_start(ready_to_start), .remote_start_in(remote_start_in)
  );

  // 10 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic end_sim();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // one write attempt; the verdict stands in the following cycle only
  task automatic net_write(input logic [15:0] a, input logic rej);
    @(negedge core_clk);
    net_wr_en = 1'b1;
    net_wr_addr = a;
    @(negedge core_clk);
    net_wr_en = 1'b0;
    `check_eq(net_wr_reject, rej, "write reject");
    `check_eq(net_wr_ok, ~rej, "write ok");
  endtask

  // blocking bits: running, inhibit, recycle, trip, local mode
  task automatic set_status(input logic [4:0] b);
    @(negedge core_clk);
    {running, start_inhibit, anti_recycle, trip} = b[4:1];
    remote_mode = ~b[0];
    repeat (3) @(negedge core_clk);
    `check_eq(ready_to_start, (b == 5'h00), "ready level");
  endtask

  // close the contact for a while, then open it; count start and stop pulses
  task automatic try_start(input int exp, input int exp_stop);
    int n;
    int m;
    n = 0;
    m = 0;
    want_start = 1'b1;
    for (int i = 0; i < 18; i++)
    begin
      @(negedge core_clk);
      n += (start_req === 1'b1);
      m += (stop_req === 1'b1);
      if (i == 11)
        want_start = 1'b0;
    end
    `check_eq(n, exp, "start pulses");
    `check_eq(m, exp_stop, "stop pulses");
  endtask

  // cycles of slide drive in each direction over a span
  task automatic drive_count(input int n);
    up_cnt = 0;
    dn_cnt = 0;
    repeat (n)
    begin
      @(negedge core_clk);
      up_cnt += (slide_inc === 1'b1);
      dn_cnt += (slide_dec === 1'b1);
    end
  endtask

  // slide target is 500; err is target minus position
  task automatic pos_case(input int err);
    int a;
    int e;
    a = (err < 0) ? -err : err;
    e = (a < 4) ? 0 : ((a < 100) ? a * SLICE : TICK);
    slide_pos_in = 10'(500 - err);
    repeat (TICK + 20) @(negedge core_clk);
    drive_count(TICK);
    `check_eq(up_cnt, (err > 0) ? e : 0, "raise time");
    `check_eq(dn_cnt, (err < 0) ? e : 0, "lower time");
  endtask

  // hangs are cut at more than twice the expected run
  initial
  begin
    repeat (60000) @(posedge core_clk);
    failures++;
    end_sim();
  end

  initial
  begin
    {failures, n_compared, want_start, obey, net_wr_en} = '0;
    {running, start_inhibit, anti_recycle, trip, direct_io} = '0;
    rst = 1'b1;
    mode = chp_pkg::CHP_SLIDE_ONLY;
    remote_mode = 1'b1;
    hold_code = 12'h800;
    slide_pos_in = 10'h1f4;
    net_wr_addr = 16'h0000;
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    direct_io = 1'b1;
    net_write(16'h9e33, 1'b0);
    net_write(16'h9e34, 1'b1);
    net_write(16'h9e41, 1'b1);
    net_write(16'h9e42, 1'b0);
    direct_io = 1'b0;
    net_write(16'h9e35, 1'b0);
    for (int i = 0; i < 5; i++)
      set_status(5'(1 << i));
    set_status(5'h00);
    obey = 1'b1;
    try_start(1, 0);
    set_status(5'h02);
    obey = 1'b0;
    try_start(0, 0);
    set_status(5'h01);
    try_start(0, 0);
    // running: the close starts nothing, the opening asks for a stop
    set_status(5'h10);
    try_start(0, 1);
    foreach (errs[i])
      pos_case(errs[i]);
    `check_eq(speed_cmd, 10'h000, "speed idle");
    mode = chp_pkg::CHP_NO_SLIDE;
    hold_code = 12'hfff;
    repeat (TICK) @(negedge core_clk);
    s0 = speed_cmd;
    repeat (100) @(negedge core_clk);
    `check_eq((speed_cmd - s0) inside {[24:26]}, 1'b1, "rate");
    drive_count(25 * TICK);
    `check_eq(up_cnt + dn_cnt, 0, "slide idle");
    `check_eq((speed_cmd >= 997), 1'b1, "speed full");
    hold_code = 12'h000;
    repeat (25 * TICK) @(negedge core_clk);
    `check_eq((speed_cmd <= 3), 1'b1, "speed zero");
    mode = chp_pkg::CHP_COMBINED;
    hold_code = 12'hc00;
    repeat (TICK + 20) @(negedge core_clk);
    drive_count(2 * TICK);
    `check_eq(up_cnt, 2 * TICK, "slide first");
    `check_eq((speed_cmd <= 3), 1'b1, "speed held");
    slide_pos_in = 10'h3e8;
    repeat (25 * TICK) @(negedge core_clk);
    `check_eq((speed_cmd >= 496 && speed_cmd <= 504), 1'b1, "split");
    hold_code = 12'h400;
    repeat (TICK + 20) @(negedge core_clk);
    drive_count(TICK);
    `check_eq(dn_cnt, TICK, "slide back");
    // a quarter of the span must land the slide at half travel
    slide_pos_in = 10'h1f4;
    repeat (TICK + 20) @(negedge core_clk);
    drive_count(TICK);
    `check_eq(up_cnt + dn_cnt, 0, "slide mapped");
    repeat (25 * TICK) @(negedge core_clk);
    `check_eq((speed_cmd <= 3), 1'b1, "speed off");
    end_sim();
  end
endmodule
`default_nettype wire
